// >>> rtl/bas_blind_access.v
// Blind access completion tracking, holding register and software reset.
// Assumes the device core reports each blind access end with a one-cycle
// done pulse plus the access address, direction and read data; the host
// port presents register reads and writes as one-cycle strobes.
`include "bas_map.vh"

module bas_blind_access #(
  parameter [2:0] SRST_CYCLES = `BAS_SRST_CYCLES
) (
  input  wire        i_ref_clk,
  input  wire        i_resetn,
  input  wire        i_ce,
  input  wire        i_reg_rd,
  input  wire        i_reg_wr,
  input  wire [8:0]  i_reg_addr,
  input  wire [31:0] i_reg_wdata,
  input  wire        i_ba_start,
  input  wire        i_ba_done,
  input  wire        i_ba_is_read,
  input  wire [8:0]  i_ba_addr,
  input  wire [31:0] i_ba_rdata,
  output reg  [31:0] o_reg_rdata,
  output reg         o_reg_rvalid,
  output reg         o_blind_access_complete,
  output reg  [31:0] o_blind_access_holding,
  output reg         o_soft_reset
);

  // ========================================================================
  // Address decode
  // The status, holding and I/O control slots are served by the host port
  // itself, so a blind access to them never moves the completion flag.
  function is_own_reg;
    input [8:0] a;
    begin
      is_own_reg = (a == `BAS_OFF_STATUS) ||
                   (a == `BAS_OFF_HOLDING) ||
                   (a == `BAS_OFF_IOCTL);
    end
  endfunction

  function is_reg;
    input [8:0] a;
    input [8:0] off;
    begin
      is_reg = (a == off);
    end
  endfunction

  // ========================================================================
  // Status word
  // One flag copied into the top bit of every byte lane, so a host on a
  // narrow bus sees it whichever lane it fetches.
  function [31:0] status_word;
    input f;
    begin
      status_word                = 32'h0000_0000;
      status_word[`BAS_CMP_BIT0] = f;
      status_word[`BAS_CMP_BIT1] = f;
      status_word[`BAS_CMP_BIT2] = f;
      status_word[`BAS_CMP_BIT3] = f;
    end
  endfunction

  // ========================================================================
  // Internal signals
  reg  [2:0]  srst_cnt_reg;
  reg  [2:0]  srst_cnt_next;
  reg         soft_reset_next;

  reg         complete_next;
  reg  [31:0] holding_next;

  reg  [31:0] rdata_next;
  reg         rvalid_next;

  wire        srst_trig;
  wire        srst_busy;
  wire        ba_counts;
  wire        ba_starts;

  // ========================================================================
  // Event decode
  // The write data is never looked at: any write to the trigger slot counts,
  // and writes to every other slot are dropped.
  assign srst_trig = i_reg_wr && is_reg(i_reg_addr, `BAS_OFF_SWRESET);

  // The counter is nonzero for exactly the cycles in which the pulse runs
  assign srst_busy = (srst_cnt_reg != 3'h0);

  assign ba_counts = i_ba_done && !is_own_reg(i_ba_addr);

  assign ba_starts = i_ba_start && !is_own_reg(i_ba_addr);

  // ========================================================================
  // Software reset pulse, next value
  // A write during the pulse restarts the count, so the pulse never ends
  // earlier than four cycles after the last trigger write.
  always @* begin
    srst_cnt_next   = srst_cnt_reg;
    soft_reset_next = 1'b0;
    if (srst_trig) begin
      srst_cnt_next   = SRST_CYCLES;
      soft_reset_next = 1'b1;
    end else if (srst_busy) begin
      srst_cnt_next   = srst_cnt_reg - 3'h1;
      soft_reset_next = (srst_cnt_reg != 3'h1);
    end
  end

  // ========================================================================
  // Software reset pulse, registers
  always @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      srst_cnt_reg <= 3'h0;
    end else if (i_ce) begin
      srst_cnt_reg <= srst_cnt_next;
    end
  end

  always @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_soft_reset <= 1'b0;
    end else if (i_ce) begin
      o_soft_reset <= soft_reset_next;
    end
  end

  // ========================================================================
  // Completion flag and holding register, next value
  // The running reset wins over everything: a completion that lands inside
  // the pulse is lost, as the rest of the device is being reset with it.
  // Completion wins over a new start in the same cycle, so a host that
  // starts the next access early never misses the flag of the last one.
  always @* begin
    complete_next = o_blind_access_complete;
    holding_next  = o_blind_access_holding;
    if (srst_busy) begin
      complete_next = 1'b0;
      holding_next  = `BAS_HOLDING_RST;
    end else if (ba_counts) begin
      complete_next = 1'b1;
      if (i_ba_is_read) begin
        holding_next = i_ba_rdata;
      end
    end else if (ba_starts) begin
      complete_next = 1'b0;
    end
  end

  // ========================================================================
  // Completion flag and holding register, registers
  always @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_blind_access_complete <= 1'b0;
    end else if (i_ce) begin
      o_blind_access_complete <= complete_next;
    end
  end

  always @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_blind_access_holding <= `BAS_HOLDING_RST;
    end else if (i_ce) begin
      o_blind_access_holding <= holding_next;
    end
  end

  // ========================================================================
  // Register read port, next value
  // Reserved and write-only slots read as zero. The status word is built
  // from the flag as it stands at the read edge, not from its next value.
  always @* begin
    rdata_next  = o_reg_rdata;
    rvalid_next = i_reg_rd;
    if (i_reg_rd) begin
      case (i_reg_addr)
        `BAS_OFF_STATUS: begin
          rdata_next = status_word(o_blind_access_complete);
        end
        `BAS_OFF_HOLDING: begin
          rdata_next = o_blind_access_holding;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // ========================================================================
  // Register read port, registers
  // Read data holds until the next read, so a slow host may fetch it late.
  always @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_ce) begin
      o_reg_rdata <= rdata_next;
    end
  end

  always @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_reg_rvalid <= 1'b0;
    end else if (i_ce) begin
      o_reg_rvalid <= rvalid_next;
    end
  end

endmodule

// >>> rtl/bas_map.vh
// Register map, field positions, reset values and timing counts for the
// blind access status and software reset block.
// Assumes a 50 MHz system clock and a quadlet-wide host register port.
`ifndef BAS_MAP_VH
`define BAS_MAP_VH

// ==========================================================================
// Register offsets
`define BAS_ADDR_W          9
`define BAS_OFF_STATUS      9'h1f0
`define BAS_OFF_HOLDING     9'h1f4
`define BAS_OFF_RESERVED    9'h1f8
`define BAS_OFF_SWRESET     9'h1fc
`define BAS_OFF_IOCTL       9'h1ec

// ==========================================================================
// Fields and reset values
`define BAS_CMP_BIT0        7
`define BAS_CMP_BIT1        15
`define BAS_CMP_BIT2        23
`define BAS_CMP_BIT3        31
`define BAS_STATUS_RST      32'h0000_0000
`define BAS_HOLDING_RST     32'h0000_0000

// ==========================================================================
// Timing
`define BAS_SRST_CYCLES     3'h4

`endif

// >>> verif/bas_core_model.sv
// Model of the core behind blind accesses: each start gets a done pulse.
// Assumes starts are further apart than the delay.
module bas_core_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [3:0] dly,
  output logic            done = 0
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  always @(negedge clk) begin
    done <= n == 1;
    n <= go ? dly : (n > 0 ? n - 1 : 0);
  end
endmodule

// >>> verif/bas_monitor.sv
// ==========================================================================
// Checker on the ports of bas_blind_access.
// Assumes the clock enable stays high, so every rising edge is a live cycle.
module bas_monitor (
  input wire logic        i_ref_clk,
  input wire logic        i_resetn,
  input wire logic        i_reg_rd,
  input wire logic        i_reg_wr,
  input wire logic        i_ba_start,
  input wire logic        i_ba_done,
  input wire logic        i_ba_is_read,
  input wire logic [8:0]  i_reg_addr,
  input wire logic [8:0]  i_ba_addr,
  input wire logic [31:0] i_ba_rdata,
  input wire logic [31:0] o_reg_rdata,
  input wire logic [31:0] o_blind_access_holding,
  input wire logic        o_reg_rvalid,
  input wire logic        o_blind_access_complete,
  input wire logic        o_soft_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  wire own = i_ba_addr == 9'h1f0 || i_ba_addr == 9'h1f4 || i_ba_addr == 9'h1ec;
  // A reset in flight may clear what a done would set
  wire calm = !o_soft_reset && !i_reg_wr;
  sequence s_pulse; o_soft_reset [*4] ##1 !o_soft_reset; endsequence
  a_status_mirror: assert property ($past(i_reg_rd && i_reg_addr == 9'h1f0) && o_reg_rvalid |->
    o_reg_rdata == {4{$past(o_blind_access_complete), 7'h0}}) else $error("status");
  a_done_sets: assert property (i_ba_done && !own && calm |=> o_blind_access_complete)
    else $error("flag");
  a_hold_load: assert property (i_ba_done && i_ba_is_read && !own && calm |=>
    o_blind_access_holding == $past(i_ba_rdata)) else $error("holding");
  a_own_ignored: assert property (i_ba_done && own && calm |=> $stable(o_blind_access_holding))
    else $error("own");
  a_start_clears: assert property (i_ba_start && !i_ba_done && !own |=> !o_blind_access_complete)
    else $error("start");
  a_srst_cause: assert property (i_reg_wr && i_reg_addr == 9'h1fc |-> ##[1:2] o_soft_reset)
    else $error("cause");
  a_srst_width: assert property ($rose(o_soft_reset) |-> s_pulse) else $error("width");
  a_srst_clears: assert property (o_soft_reset ##1 o_soft_reset |->
    !o_blind_access_complete && o_blind_access_holding == 0) else $error("clear");
endmodule

// >>> verif/bas_blind_access_test.sv
// ====
// Bench: host register tasks drive bas_blind_access; the core model ends accesses.
module bas_blind_access_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk = 0, i_resetn = 0, i_ce = 1, i_reg_rd = 0, i_reg_wr = 0, i_ba_start = 0, i_ba_is_read = 0, i_ba_done;
  logic [8:0]  i_reg_addr = 0, i_ba_addr = 0;
  logic [31:0] i_reg_wdata = 32'h5a5a_0f0f, i_ba_rdata = 0, o_reg_rdata, o_blind_access_holding;
  logic        o_reg_rvalid, o_blind_access_complete, o_soft_reset;
  int n_mismatch = 0, checks = 0, k;
  bas_blind_access uut (
    .i_ref_clk               (i_ref_clk),
    .i_resetn                (i_resetn),
    .i_ce                    (i_ce),
    .i_reg_rd                (i_reg_rd),
    .i_reg_wr                (i_reg_wr),
    .i_reg_addr              (i_reg_addr),
    .i_reg_wdata             (i_reg_wdata),
    .i_ba_start              (i_ba_start),
    .i_ba_done               (i_ba_done),
    .i_ba_is_read            (i_ba_is_read),
    .i_ba_addr               (i_ba_addr),
    .i_ba_rdata              (i_ba_rdata),
    .o_reg_rdata             (o_reg_rdata),
    .o_reg_rvalid            (o_reg_rvalid),
    .o_blind_access_complete (o_blind_access_complete),
    .o_blind_access_holding  (o_blind_access_holding),
    .o_soft_reset            (o_soft_reset)
  );
  bas_core_model core (.clk(i_ref_clk), .go(i_ba_start), .dly(4'h3), .done(i_ba_done));
  initial forever #10 i_ref_clk = ~i_ref_clk;
  task chk(input string s, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin n_mismatch++; $display("FAIL %s exp %h got %h", s, e, g); end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task rreg(input logic [8:0] a, input logic [31:0] e, input bit c);
    @(negedge i_ref_clk) begin i_reg_rd <= 1; i_reg_addr <= a; end
    @(negedge i_ref_clk) i_reg_rd <= 0;
    chk("rvalid", 1, o_reg_rvalid);
    if (c) chk("rdata", e, o_reg_rdata);
  endtask
  task bacc(input logic [8:0] a, input logic r, input logic [31:0] d);
    @(negedge i_ref_clk) begin i_ba_start <= 1; i_ba_addr <= a; i_ba_is_read <= r; i_ba_rdata <= d; end
    @(negedge i_ref_clk) i_ba_start <= 0;
    k = 0;
    do begin rreg(9'h1f0, 0, 0); k++; end while (o_reg_rdata[7] !== 1'b1 && k < 20);
    if (o_reg_rdata[7] !== 1'b1) begin n_mismatch++; test_done; end
  endtask
  initial begin
    repeat (3) @(negedge i_ref_clk);
    i_resetn <= 1;
    rreg(9'h1f0, 0, 1);
    rreg(9'h1f4, 0, 1);
    rreg(9'h1f8, 0, 1);
    $display("test reset done");
    bacc(9'h010, 1, 32'hc3c3_1234);
    rreg(9'h1f0, 32'h8080_8080, 1);
    rreg(9'h1f4, 32'hc3c3_1234, 1);
    bacc(9'h1ec, 1, 32'h0000_0bad);
    repeat (6) @(negedge i_ref_clk);
    rreg(9'h1f4, 32'hc3c3_1234, 1);
    bacc(9'h020, 0, 32'h1);
    rreg(9'h1f4, 32'hc3c3_1234, 1);
    $display("test access done");
    @(negedge i_ref_clk) begin i_reg_wr <= 1; i_reg_addr <= 9'h1f0; end
    @(negedge i_ref_clk) i_reg_wr <= 0;
    chk("no pulse", 0, o_soft_reset);
    rreg(9'h1fc, 0, 1);
    @(negedge i_ref_clk) begin i_reg_wr <= 1; i_reg_addr <= 9'h1fc; end
    @(negedge i_ref_clk) i_reg_wr <= 0;
    k = o_soft_reset;
    repeat (8) @(negedge i_ref_clk) k += o_soft_reset;
    chk("pulse", 4, k);
    rreg(9'h1f0, 0, 1);
    rreg(9'h1f4, 0, 1);
    $display("test soft reset done");
    bacc(9'h030, 1, 32'h7e7e_0001);
    @(negedge i_ref_clk) i_resetn <= 0;
    repeat (2) @(negedge i_ref_clk);
    i_resetn <= 1;
    rreg(9'h1f0, 0, 1);
    rreg(9'h1f4, 0, 1);
    $display("test hard reset done");
    test_done;
  end
endmodule

bind bas_blind_access bas_monitor mon (
  .i_ref_clk               (i_ref_clk),
  .i_resetn                (i_resetn),
  .i_reg_rd                (i_reg_rd),
  .i_reg_wr                (i_reg_wr),
  .i_ba_start              (i_ba_start),
  .i_ba_done               (i_ba_done),
  .i_ba_is_read            (i_ba_is_read),
  .i_reg_addr              (i_reg_addr),
  .i_ba_addr               (i_ba_addr),
  .i_ba_rdata              (i_ba_rdata),
  .o_reg_rdata             (o_reg_rdata),
  .o_blind_access_holding  (o_blind_access_holding),
  .o_reg_rvalid            (o_reg_rvalid),
  .o_blind_access_complete (o_blind_access_complete),
  .o_soft_reset            (o_soft_reset)
);
